// >>> verilog/lpf_pkg.sv
package lpf_pkg;
    // Stream and line geometry
    localparam int CHAR_W = 6;
    localparam int COL_W = 7;
    localparam int REP_W = 4;
    localparam int LINE_COLS = 120;
    localparam int DUMP_COLS = 64;
    localparam int REPORTS = 15;
    localparam int FIFO_DEPTH = 8;
    localparam logic [6:0] LINE_MAX = 7'h78;
    localparam logic [6:0] DUMP_MAX = 7'h40;
    localparam logic [6:0] COL_ONE = 7'h01;
    localparam logic [6:0] COL_ZERO = 7'h00;
    // Character codes
    localparam logic [5:0] CH_FILL = 6'h00;
    localparam logic [5:0] CH_SPACE = 6'h01;
    localparam logic [5:0] CH_EOL = 6'h02;
    localparam logic [5:0] CH_VFMT = 6'h03;
    localparam logic [1:0] DS_PREFIX = 2'h3;
    localparam logic [3:0] REP_ALL = 4'h0;
    // Reset values
    localparam logic [3:0] REP_RESET = 4'h0;
    localparam logic [5:0] CHAR_RESET = 6'h00;
    // Alarm lamp timing
    localparam int CLK_HZ = 25000000;
    localparam int FLASH_HALF_MS = 250;
    localparam int FLASH_CYC = FLASH_HALF_MS * (CLK_HZ / 1000);
    // Formatter states
    typedef enum logic [1:0] {
        ST_RUN = 2'b01,
        ST_WAIT = 2'b10
    } lpf_state_t;
endpackage : lpf_pkg

// >>> verilog/lpf_fifo.sv
`timescale 1ns/1ps
module lpf_fifo #(
    parameter int W = 7,
    parameter int D = 8
) (
    // Clock and reset
    input wire logic clk,
    input wire logic rst_n,
    // Fill side
    input wire logic in_valid,
    output logic in_ready,
    input wire logic [W-1:0] in_data,
    // Drain side
    output logic out_valid,
    input wire logic out_ready,
    output logic [W-1:0] out_data
);
    localparam int AW = (D > 1) ? $clog2(D) : 1;
    localparam int CW = $clog2(D + 1);
    logic [W-1:0] mem [D];
    logic [AW-1:0] wr_ptr, rd_ptr, next_wr_ptr, next_rd_ptr;
    logic [CW-1:0] count, next_count;
    logic next_in_ready, next_out_valid, push, take;

    assign out_data = mem[rd_ptr];

    always_comb
    begin
        push = in_valid && in_ready;
        take = out_valid && out_ready;
        next_wr_ptr = wr_ptr;
        next_rd_ptr = rd_ptr;
        if (push)
            next_wr_ptr = (wr_ptr == AW'(D - 1)) ? '0 : AW'(wr_ptr + 1'b1);
        if (take)
            next_rd_ptr = (rd_ptr == AW'(D - 1)) ? '0 : AW'(rd_ptr + 1'b1);
        next_count = CW'(count + CW'(push) - CW'(take));
        next_in_ready = (next_count != CW'(D));
        next_out_valid = (next_count != '0);
    end

    always_ff @(posedge clk or negedge rst_n)
    begin
        if (!rst_n)
        begin
            wr_ptr <= '0;
            rd_ptr <= '0;
            count <= '0;
            in_ready <= 1'b0;
            out_valid <= 1'b0;
        end
        else
        begin
            wr_ptr <= next_wr_ptr;
            rd_ptr <= next_rd_ptr;
            count <= next_count;
            in_ready <= next_in_ready;
            out_valid <= next_out_valid;
        end
    end

    always_ff @(posedge clk)
    begin
        if (push)
            mem[wr_ptr] <= in_data;
    end

    property p_hold;
        @(posedge clk) disable iff (!rst_n)
        out_valid && !out_ready |=> out_valid && $stable(out_data);
    endproperty
    a_hold: assert property (p_hold) // RL13
        else $error("fifo head changed while stalled");
endmodule : lpf_fifo

// >>> verilog/lpf_hammer_chk.sv
`timescale 1ns/1ps
module lpf_hammer_chk #(
    parameter int COLS = 120
) (
    // Clock and reset
    input wire logic clk,
    input wire logic rst_n,
    // Check request
    input wire logic check,
    input wire logic [COLS-1:0] expect_fire,
    input wire logic [COLS-1:0] echo,
    // Result
    output logic fault
);
    logic next_fault;

    always_comb
    begin
        // RL12 compare hammer echo
        next_fault = check && (expect_fire != echo);
    end

    always_ff @(posedge clk or negedge rst_n)
    begin
        if (!rst_n)
            fault <= 1'b0;
        else
            fault <= next_fault;
    end

    property p_miss;
        @(posedge clk) disable iff (!rst_n)
        check && (expect_fire != echo) |=> fault ##1 !fault;
    endproperty
    a_miss: assert property (p_miss) // RL12
        else $error("hammer mismatch not reported");
endmodule : lpf_hammer_chk

// >>> verilog/lpf_format.sv
// Functional notes
// RL1 - Line holds at most 120 columns
// RL2 - Filler prints nothing, count unchanged
// RL3 - Space leaves blank column, count plus one
// RL4 - End-of-line prints current line
// RL5 - Count printable only, excluding select, vertical
// RL6 - Block must end on end-of-line
// RL7 - Overflow: error, print line, optional stop
// RL8 - Fault drives tone, lamp, error signal
// RL9 - Data-select picks one of 15 reports
// RL10 - Dump mode prints everything, 64 per line
// RL11 - Paper tear or exhaustion halts printing
// RL12 - Check every hammer circuit acted
// RL13 - One 6-bit code per valid/ready transfer
`timescale 1ns/1ps
module lpf_format
    import lpf_pkg::*;
#(
    parameter int FLASH_CYCLES = FLASH_CYC
) (
    // Clock and reset
    input wire logic sys_clk,
    input wire logic nrst,
    // Character stream from buffer-controller
    input wire logic in_valid,
    output logic in_ready,
    input wire logic [5:0] in_char,
    input wire logic in_last,
    // Switches and sensors
    input wire logic dump_mode,
    input wire logic stop_on_ovf,
    input wire logic [3:0] sel_report,
    input wire logic paper_fault,
    input wire logic volt_fault,
    input wire logic fault_clear,
    // Print column and line strobes
    output logic pr_valid,
    output logic [6:0] pr_col,
    output logic [5:0] pr_char,
    output logic pr_blank,
    output logic pr_line,
    output logic [6:0] pr_len,
    // Hammer drive and sense
    output logic [LINE_COLS-1:0] hammer_expect,
    input wire logic hammer_done,
    input wire logic [LINE_COLS-1:0] hammer_echo,
    // Faults and alarms
    output logic fault_ovf,
    output logic fault_eob,
    output logic fault_hammer,
    output logic err_to_buf,
    output logic alarm_tone,
    output logic alarm_lamp,
    output logic halted,
    output logic [3:0] cur_report
);
    localparam int FW = $clog2(FLASH_CYCLES + 1);
    localparam logic [FW-1:0] FLASH_LAST = FW'(FLASH_CYCLES - 1);

    // Reset release
    logic rst_meta, rst_n;
    always_ff @(posedge sys_clk or negedge nrst)
    begin
        if (!nrst)
        begin
            rst_meta <= 1'b0;
            rst_n <= 1'b0;
        end
        else
        begin
            rst_meta <= 1'b1;
            rst_n <= rst_meta;
        end
    end

    // Input buffer
    logic f_valid, pop, f_last, chk, ham_fault;
    logic [5:0] f_char;
    logic [6:0] f_data;
    // RL13 handshake buffer
    lpf_fifo #(
        .W(CHAR_W + 1),
        .D(FIFO_DEPTH)
    ) lpf_fifo_i (
        .clk(sys_clk),
        .rst_n(rst_n),
        .in_valid(in_valid),
        .in_ready(in_ready),
        .in_data({in_last, in_char}),
        .out_valid(f_valid),
        .out_ready(pop),
        .out_data(f_data)
    );
    assign f_char = f_data[5:0];
    assign f_last = f_data[6];

    lpf_hammer_chk #(
        .COLS(LINE_COLS)
    ) lpf_hammer_chk_i (
        .clk(sys_clk),
        .rst_n(rst_n),
        .check(chk),
        .expect_fire(hammer_expect),
        .echo(hammer_echo),
        .fault(ham_fault)
    );

    // Formatter state
    lpf_state_t state, next_state;
    logic [6:0] count, next_count, next_pr_col, next_pr_len;
    logic [3:0] next_report;
    logic [5:0] next_pr_char;
    logic [LINE_COLS-1:0] next_mask;
    logic next_pr_valid, next_pr_blank, next_pr_line, set_ovf, set_eob;

    // Character decode
    logic is_fill, is_space, is_eol, is_vf, is_ds, selected, printable, ovf_hit, run_ok;
    always_comb
    begin
        // RL2 filler never printable
        is_fill = (f_char == CH_FILL);
        is_space = (f_char == CH_SPACE);
        is_eol = (f_char == CH_EOL);
        is_vf = (f_char == CH_VFMT);
        is_ds = (f_char[5:4] == DS_PREFIX) && (f_char[3:0] != REP_ALL);
        // RL9 report selection
        selected = (sel_report == REP_ALL) || (cur_report == sel_report);
        // RL5 printable class
        printable = selected && !is_fill && !is_eol && !is_vf && !is_ds;
        // RL1 line full check
        ovf_hit = printable && (count == LINE_MAX);
        // RL11 halt conditions
        run_ok = !paper_fault && !volt_fault && !(stop_on_ovf && fault_ovf);
    end

    always_comb
    begin
        next_state = state;
        next_count = count;
        next_report = cur_report;
        next_mask = hammer_expect;
        next_pr_valid = 1'b0;
        next_pr_col = pr_col;
        next_pr_char = pr_char;
        next_pr_blank = pr_blank;
        next_pr_line = 1'b0;
        next_pr_len = pr_len;
        set_ovf = 1'b0;
        set_eob = 1'b0;
        pop = 1'b0;
        chk = 1'b0;
        case (state)
            ST_RUN:
            begin
                if (f_valid && run_ok)
                begin
                    if (dump_mode)
                    begin
                        // RL10 dump every code
                        pop = 1'b1;
                        next_pr_valid = 1'b1;
                        next_pr_col = count;
                        next_pr_char = f_char;
                        next_pr_blank = 1'b0;
                        next_mask[count] = 1'b1;
                        next_count = 7'(count + COL_ONE);
                        if (count == 7'(DUMP_MAX - COL_ONE) || f_last)
                        begin
                            next_pr_line = 1'b1;
                            next_pr_len = 7'(count + COL_ONE);
                            next_count = COL_ZERO;
                            next_state = ST_WAIT;
                        end
                    end
                    else if (ovf_hit)
                    begin
                        // RL7 print and flag
                        set_ovf = 1'b1;
                        next_pr_line = 1'b1;
                        next_pr_len = count;
                        next_count = COL_ZERO;
                        next_state = ST_WAIT;
                    end
                    else
                    begin
                        pop = 1'b1;
                        if (is_ds)
                            // RL9 switch report
                            next_report = f_char[3:0];
                        else if (printable)
                        begin
                            // RL3 space leaves blank
                            next_pr_valid = 1'b1;
                            next_pr_col = count;
                            next_pr_char = f_char;
                            next_pr_blank = is_space;
                            next_mask[count] = !is_space;
                            next_count = 7'(count + COL_ONE);
                        end
                        else if (selected && is_eol)
                        begin
                            // RL4 line complete
                            next_pr_line = 1'b1;
                            next_pr_len = count;
                            next_count = COL_ZERO;
                            next_state = ST_WAIT;
                        end
                        // RL6 block end check
                        if (f_last && !is_eol)
                            set_eob = 1'b1;
                    end
                end
            end
            ST_WAIT:
            begin
                if (hammer_done)
                begin
                    // RL12 check after print
                    chk = 1'b1;
                    next_mask = '0;
                    next_state = ST_RUN;
                end
            end
            default:
                next_state = ST_RUN;
        endcase
    end

    always_ff @(posedge sys_clk or negedge rst_n)
    begin
        if (!rst_n)
        begin
            state <= ST_RUN;
            count <= COL_ZERO;
            cur_report <= REP_RESET;
            hammer_expect <= '0;
            pr_valid <= 1'b0;
            pr_col <= COL_ZERO;
            pr_char <= CHAR_RESET;
            pr_blank <= 1'b0;
            pr_line <= 1'b0;
            pr_len <= COL_ZERO;
        end
        else
        begin
            state <= next_state;
            count <= next_count;
            cur_report <= next_report;
            hammer_expect <= next_mask;
            pr_valid <= next_pr_valid;
            pr_col <= next_pr_col;
            pr_char <= next_pr_char;
            pr_blank <= next_pr_blank;
            pr_line <= next_pr_line;
            pr_len <= next_pr_len;
        end
    end

    // Sticky faults and alarms
    logic next_f_ovf, next_f_eob, next_f_ham, any_next, next_halted, next_lamp;
    logic [FW-1:0] flash_cnt, next_flash_cnt;
    always_comb
    begin
        // Set wins over clear
        next_f_ovf = set_ovf || (fault_ovf && !fault_clear);
        next_f_eob = set_eob || (fault_eob && !fault_clear);
        next_f_ham = ham_fault || (fault_hammer && !fault_clear);
        // RL8 fault alarms
        any_next = next_f_ovf || next_f_eob || next_f_ham;
        next_halted = !run_ok;
        next_flash_cnt = flash_cnt;
        next_lamp = alarm_lamp;
        if (!any_next)
        begin
            next_flash_cnt = '0;
            next_lamp = 1'b0;
        end
        else if (!(fault_ovf || fault_eob || fault_hammer))
        begin
            next_flash_cnt = '0;
            next_lamp = 1'b1;
        end
        else if (flash_cnt == FLASH_LAST)
        begin
            next_flash_cnt = '0;
            next_lamp = !alarm_lamp;
        end
        else
            next_flash_cnt = FW'(flash_cnt + 1'b1);
    end

    always_ff @(posedge sys_clk or negedge rst_n)
    begin
        if (!rst_n)
        begin
            fault_ovf <= 1'b0;
            fault_eob <= 1'b0;
            fault_hammer <= 1'b0;
            err_to_buf <= 1'b0;
            alarm_tone <= 1'b0;
            alarm_lamp <= 1'b0;
            halted <= 1'b0;
            flash_cnt <= '0;
        end
        else
        begin
            fault_ovf <= next_f_ovf;
            fault_eob <= next_f_eob;
            fault_hammer <= next_f_ham;
            err_to_buf <= any_next;
            alarm_tone <= any_next;
            alarm_lamp <= next_lamp;
            halted <= next_halted;
            flash_cnt <= next_flash_cnt;
        end
    end

    property p_max;
        @(posedge sys_clk) disable iff (!rst_n)
        count <= LINE_MAX;
    endproperty
    a_max: assert property (p_max) // RL1
        else $error("line count above limit");

    property p_fill;
        @(posedge sys_clk) disable iff (!rst_n)
        pop && !dump_mode && is_fill |=> $stable(count) && !pr_valid;
    endproperty
    a_fill: assert property (p_fill) // RL2
        else $error("filler changed count or printed");

    property p_space;
        @(posedge sys_clk) disable iff (!rst_n)
        pop && !dump_mode && is_space && selected |=> pr_valid && pr_blank && count == 7'($past(count) + COL_ONE);
    endproperty
    a_space: assert property (p_space) // RL3
        else $error("space did not advance one blank column");

    property p_eol;
        @(posedge sys_clk) disable iff (!rst_n)
        pop && !dump_mode && is_eol && selected |=> pr_line && pr_len == $past(count) && count == COL_ZERO;
    endproperty
    a_eol: assert property (p_eol) // RL4
        else $error("end of line did not print line");

    property p_ds;
        @(posedge sys_clk) disable iff (!rst_n)
        pop && !dump_mode && is_ds |=> $stable(count) && cur_report == $past(f_char[3:0]);
    endproperty
    a_ds: assert property (p_ds) // RL5
        else $error("data select counted or not taken");

    property p_eob;
        @(posedge sys_clk) disable iff (!rst_n)
        pop && !dump_mode && f_last && !is_eol |=> fault_eob ##1 err_to_buf;
    endproperty
    a_eob: assert property (p_eob) // RL6
        else $error("bad block end not flagged");

    property p_ovf;
        @(posedge sys_clk) disable iff (!rst_n)
        state == ST_RUN && f_valid && run_ok && !dump_mode && ovf_hit |=> pr_line && pr_len == LINE_MAX && fault_ovf;
    endproperty
    a_ovf: assert property (p_ovf) // RL7
        else $error("overflow not printed and flagged");

    property p_stop;
        @(posedge sys_clk) disable iff (!rst_n)
        fault_ovf && stop_on_ovf && !fault_clear |=> !pop;
    endproperty
    a_stop: assert property (p_stop) // RL7
        else $error("printing went on after overflow stop");

    property p_alarm;
        @(posedge sys_clk) disable iff (!rst_n)
        $rose(fault_hammer) |-> err_to_buf && alarm_tone && alarm_lamp;
    endproperty
    a_alarm: assert property (p_alarm) // RL8
        else $error("fault without alarms");

    property p_dump;
        @(posedge sys_clk) disable iff (!rst_n)
        pop && dump_mode |=> pr_valid && pr_char == $past(f_char) && count <= DUMP_MAX;
    endproperty
    a_dump: assert property (p_dump) // RL10
        else $error("dump character not printed");

    property p_paper;
        @(posedge sys_clk) disable iff (!rst_n)
        paper_fault |-> !pop ##1 halted;
    endproperty
    a_paper: assert property (p_paper) // RL11
        else $error("printing during paper fault");
endmodule : lpf_format

// >>> sim/lpf_bufctl_model.sv
`timescale 1ns/1ps
module lpf_bufctl_model (
    // Clock
    input wire logic clk,
    // Character stream to printer
    output logic valid,
    input wire logic ready,
    output logic [5:0] ch,
    output logic last
);
    int gap = 0;
    int n_taken = 0;

    initial
    begin
        valid = 1'b0;
        ch = 6'h2A;
        last = 1'b0;
    end

    task send(input logic [5:0] c, input logic l);
        repeat (gap) @(negedge clk);
        @(negedge clk);
        valid = 1'b1;
        ch = c;
        last = l;
        while (ready !== 1'b1)
        begin
            @(negedge clk);
        end
        @(negedge clk);
        n_taken++;
        valid = 1'b0;
        // Idle lines show no stale character
        ch = ~c;
        last = ~l;
    endtask : send
endmodule : lpf_bufctl_model

// >>> sim/lpf_format_bench.sv
`timescale 1ns/1ps
module lpf_format_bench
    import lpf_pkg::*;
;
    logic sys_clk = 1'b0;
    logic nrst = 1'b0;
    logic dump_mode = 1'b0, stop_on_ovf = 1'b0, paper_fault = 1'b0, volt_fault = 1'b0;
    logic fault_clear = 1'b0, hammer_done = 1'b0;
    logic [3:0] sel_report = 4'h0;
    logic [LINE_COLS-1:0] hammer_echo = '0;
    logic [LINE_COLS-1:0] fire = '0;
    logic [LINE_COLS-1:0] hammer_expect;
    logic in_valid, in_ready, in_last, pr_valid, pr_blank, pr_line, fault_ovf, fault_eob, fault_hammer;
    logic err_to_buf, alarm_tone, alarm_lamp, halted;
    logic [5:0] in_char, pr_char;
    logic [6:0] pr_col, pr_len;
    logic [3:0] cur_report;
    int miscompares = 0;
    int n_compared = 0;
    int cyc = 0;
    logic [13:0] pv_q[$];
    logic [13:0] got[$];
    logic [6:0] ln_q[$];

    always #20 sys_clk = ~sys_clk;

    lpf_format #(.FLASH_CYCLES(4)) lpf_format_i (.sys_clk(sys_clk), .nrst(nrst), .in_valid(in_valid),
        .in_ready(in_ready), .in_char(in_char), .in_last(in_last), .dump_mode(dump_mode),
        .stop_on_ovf(stop_on_ovf), .sel_report(sel_report), .paper_fault(paper_fault),
        .volt_fault(volt_fault), .fault_clear(fault_clear), .pr_valid(pr_valid), .pr_col(pr_col),
        .pr_char(pr_char), .pr_blank(pr_blank), .pr_line(pr_line), .pr_len(pr_len),
        .hammer_expect(hammer_expect), .hammer_done(hammer_done), .hammer_echo(hammer_echo),
        .fault_ovf(fault_ovf), .fault_eob(fault_eob), .fault_hammer(fault_hammer), .err_to_buf(err_to_buf),
        .alarm_tone(alarm_tone), .alarm_lamp(alarm_lamp), .halted(halted), .cur_report(cur_report));

    lpf_bufctl_model lpf_bufctl_model_i (.clk(sys_clk), .valid(in_valid), .ready(in_ready),
        .ch(in_char), .last(in_last));

    // Column and line monitor, run limit
    always @(posedge sys_clk)
    begin
        cyc++;
        if (pr_valid === 1'b1)
        begin
            pv_q.push_back({pr_blank, pr_col, pr_char});
            if (pr_blank !== 1'b1)
            begin
                fire[pr_col] = 1'b1;
            end
        end
        if (pr_line === 1'b1)
        begin
            ln_q.push_back(pr_len);
        end
        if (cyc == 20000)
        begin
            miscompares++;
            finish_test();
        end
    end

    task chk(input string what, input logic [31:0] seen, input logic [31:0] exp);
        n_compared++;
        if (seen !== exp)
        begin
            miscompares++;
            $display("unexpected %s: expected %0h, seen %0h", what, exp, seen);
        end
    endtask : chk

    task wait_cyc(input int n);
        repeat (n) @(negedge sys_clk);
    endtask : wait_cyc

    task tx(input logic [5:0] c, input logic l);
        lpf_bufctl_model_i.send(c, l);
    endtask : tx

    task clear_faults();
        fault_clear = 1'b1;
        @(negedge sys_clk);
        fault_clear = 1'b0;
        wait_cyc(2);
    endtask : clear_faults

    // Waits for a printed line, checks it, then strikes it with a good or bad echo
    task take_line(input logic [6:0] len, input int ncols, input logic bad);
        int i;
        i = 0;
        while (ln_q.size() == 0 && i < 400)
        begin
            @(negedge sys_clk);
            i++;
        end
        chk("line count", ln_q.size(), 1);
        chk("line length", ln_q.pop_front(), len);
        chk("columns", pv_q.size(), ncols);
        got = pv_q;
        pv_q.delete();
        wait_cyc(2);
        chk("hammer pattern", hammer_expect === fire, 1'b1);
        hammer_echo = fire ^ {{(LINE_COLS-1){1'b0}}, bad};
        hammer_done = 1'b1;
        @(negedge sys_clk);
        hammer_done = 1'b0;
        fire = '0;
        wait_cyc(4);
    endtask : take_line

    task col_chk(input int k, input logic b, input logic [6:0] col, input logic [5:0] c);
        chk("column", b ? got[k][13:6] : got[k], b ? {b, col} : {b, col, c});
    endtask : col_chk

    task t_basic();
        tx(CH_FILL, 1'b0);
        tx(6'h21, 1'b0);
        tx(CH_SPACE, 1'b0);
        tx(CH_VFMT, 1'b0);
        tx(CH_FILL, 1'b0);
        tx(6'h22, 1'b0);
        tx(CH_EOL, 1'b1);
        take_line(7'h03, 3, 1'b0);
        col_chk(0, 1'b0, 7'h00, 6'h21);
        col_chk(1, 1'b1, 7'h01, 6'h01);
        col_chk(2, 1'b0, 7'h02, 6'h22);
        chk("block end fault", fault_eob, 1'b0);
        chk("hammer fault", fault_hammer, 1'b0);
        $display("test basic done");
    endtask : t_basic

    task t_select();
        sel_report = 4'h2;
        lpf_bufctl_model_i.gap = 3;
        tx(6'h32, 1'b0);
        tx(6'h21, 1'b0);
        tx(6'h33, 1'b0);
        tx(6'h22, 1'b0);
        tx(CH_EOL, 1'b0);
        tx(6'h32, 1'b0);
        tx(6'h23, 1'b0);
        tx(CH_EOL, 1'b1);
        take_line(7'h02, 2, 1'b0);
        col_chk(0, 1'b0, 7'h00, 6'h21);
        col_chk(1, 1'b0, 7'h01, 6'h23);
        chk("report", cur_report, 4'h2);
        lpf_bufctl_model_i.gap = 0;
        sel_report = 4'h0;
        $display("test select done");
    endtask : t_select

    task t_hammer();
        int t;
        logic p;
        tx(6'h21, 1'b0);
        tx(CH_EOL, 1'b1);
        take_line(7'h01, 1, 1'b1);
        chk("hammer fault", fault_hammer, 1'b1);
        chk("error signal", err_to_buf, 1'b1);
        chk("tone", alarm_tone, 1'b1);
        t = 0;
        p = alarm_lamp;
        repeat (12)
        begin
            @(negedge sys_clk);
            t += (alarm_lamp !== p);
            p = alarm_lamp;
        end
        chk("lamp flashing", t >= 2, 1'b1);
        clear_faults();
        chk("error cleared", err_to_buf, 1'b0);
        $display("test hammer done");
    endtask : t_hammer

    task t_eob();
        tx(6'h21, 1'b1);
        wait_cyc(6);
        chk("block end fault", fault_eob, 1'b1);
        chk("error signal", err_to_buf, 1'b1);
        clear_faults();
        chk("block end cleared", fault_eob, 1'b0);
        tx(CH_EOL, 1'b1);
        take_line(7'h01, 1, 1'b0);
        $display("test block end done");
    endtask : t_eob

    task t_halt();
        for (int k = 0; k < 2; k++)
        begin
            paper_fault = (k == 0);
            volt_fault = (k == 1);
            tx(6'h24, 1'b0);
            wait_cyc(10);
            chk("halted", halted, 1'b1);
            chk("no print while halted", pv_q.size(), 0);
            paper_fault = 1'b0;
            volt_fault = 1'b0;
            tx(CH_EOL, 1'b1);
            take_line(7'h01, 1, 1'b0);
        end
        $display("test halt done");
    endtask : t_halt

    task t_overflow();
        int base;
        stop_on_ovf = 1'b1;
        base = lpf_bufctl_model_i.n_taken;
        for (int i = 0; i < 121; i++)
        begin
            tx(6'h25, 1'b0);
        end
        fork
            begin
                for (int i = 0; i < 10; i++)
                begin
                    tx(6'h26, 1'b0);
                end
                tx(CH_EOL, 1'b1);
            end
            begin
                take_line(7'h78, 120, 1'b0);
                wait_cyc(20);
                chk("overflow fault", fault_ovf, 1'b1);
                chk("error signal", err_to_buf, 1'b1);
                chk("halted", halted, 1'b1);
                chk("fifo full", in_ready, 1'b0);
                chk("words taken", lpf_bufctl_model_i.n_taken - base, 128);
                clear_faults();
            end
        join
        take_line(7'h0B, 11, 1'b0);
        col_chk(0, 1'b0, 7'h00, 6'h25);
        chk("overflow cleared", fault_ovf, 1'b0);
        stop_on_ovf = 1'b0;
        $display("test overflow done");
    endtask : t_overflow

    task t_dump();
        dump_mode = 1'b1;
        for (int i = 0; i < 64; i++)
        begin
            tx(i[5:0], 1'b0);
        end
        take_line(7'h40, 64, 1'b0);
        for (int i = 0; i < 64; i++)
        begin
            chk("dump char", got[i][5:0], i[5:0]);
        end
        dump_mode = 1'b0;
        $display("test dump done");
    endtask : t_dump

    task finish_test();
        $display("compared %0d, mismatches %0d", n_compared, miscompares);
        if (miscompares == 0 && n_compared > 0)
        begin
            $display("SIMULATION PASSED");
        end
        else
        begin
            $display("SIMULATION FAILED");
        end
        $finish;
    endtask : finish_test

    initial
    begin
        wait_cyc(10);
        nrst = 1'b1;
        wait_cyc(4);
        t_basic();
        t_select();
        t_hammer();
        t_eob();
        t_halt();
        t_overflow();
        t_dump();
        finish_test();
    end
endmodule : lpf_format_bench
